/* verilog/i2csr_pkg.sv */
package i2csr_pkg;

  // clock rate and bus timing
  localparam int CLK_MHZ         = 200;
  localparam int T_START_HOLD_NS = 600;
  localparam int T_STOP_BUF_NS   = 1300;
  localparam int START_HOLD_CYC  = (T_START_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int STOP_BUF_CYC    = (T_STOP_BUF_NS * CLK_MHZ + 999) / 1000;
  localparam int TCNT_W          = 10;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL_SET = 5'h00;
  localparam logic [4:0] OFS_CTRL_CLR = 5'h04;
  localparam logic [4:0] OFS_STATUS   = 5'h08;
  localparam logic [4:0] OFS_DATA     = 5'h0C;
  localparam logic [4:0] OFS_OWN_ADDR = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

  // control_set_register bit positions
  localparam int CTL_AA  = 2;
  localparam int CTL_SI  = 3;
  localparam int CTL_STO = 4;
  localparam int CTL_STA = 5;
  localparam int CTL_EN  = 6;

  // interrupt status bits
  localparam int IRQ_SI    = 0;
  localparam int IRQ_STOP  = 1;
  localparam int IRQ_START = 2;
  localparam int IRQ_W     = 3;

  // status codes, general call address and bits per byte
  localparam logic [7:0] STS_START_SENT = 8'h08;
  localparam logic [7:0] STS_OWN_W      = 8'h60;
  localparam logic [7:0] STS_ARB_OWN_W  = 8'h68;
  localparam logic [7:0] STS_GC         = 8'h70;
  localparam logic [7:0] STS_ARB_GC     = 8'h78;
  localparam logic [7:0] STS_OWN_ACK    = 8'h80;
  localparam logic [7:0] STS_OWN_NACK   = 8'h88;
  localparam logic [7:0] STS_GC_ACK     = 8'h90;
  localparam logic [7:0] STS_GC_NACK    = 8'h98;
  localparam logic [7:0] STS_NONE       = 8'hF8;
  localparam logic [7:0] GC_ADDR        = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_DATA, ST_ACK, ST_HOLD, ST_SKIP, ST_GEN, ST_MST, ST_STOP
  } i2csr_state_t;

endpackage

/* verilog/i2csr_sync.sv */
`timescale 1ns/100ps
module i2csr_sync
  import i2csr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } i2csr_sync_t;

  i2csr_sync_t r_r;
  i2csr_sync_t r_nxt;

  // two-stage synchroniser, idle bus level is high
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = pin_in;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_r <= '{s1: 2'h3, s2: 2'h3};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign pin_sync = r_r.s2;

endmodule

/* verilog/i2csr_cond.sv */
`timescale 1ns/100ps
module i2csr_cond
  import i2csr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic scl_s,
  input  wire logic sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  typedef struct packed {
    logic scl_d;
    logic sda_d;
  } i2csr_cond_t;

  i2csr_cond_t r_r;
  i2csr_cond_t r_nxt;

  // previous levels of both lines
  always_comb begin
    r_nxt       = r_r;
    r_nxt.scl_d = scl_s;
    r_nxt.sda_d = sda_s;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_r <= '{scl_d: 1'b1, sda_d: 1'b1};
    end else begin
      r_r <= r_nxt;
    end
  end

  // edges and bus conditions, start/stop only while clock stays high
  assign scl_rise  = scl_s & ~r_r.scl_d;
  assign scl_fall  = ~scl_s & r_r.scl_d;
  assign start_det = scl_s & r_r.scl_d & r_r.sda_d & ~sda_s;
  assign stop_det  = scl_s & r_r.scl_d & ~r_r.sda_d & sda_s;

endmodule

/* verilog/i2csr_slave_rx.sv */
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module i2csr_slave_rx
  import i2csr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // open-drain bus lines
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);

  typedef struct packed {
    i2csr_state_t        st;
    logic [3:0]          bitcnt;
    logic [7:0]          shift;
    logic [7:0]          data;
    logic [7:0]          status;
    logic [7:0]          status_pend;
    logic [7:0]          own_addr;
    logic                aa;
    logic                si;
    logic                start_request_bit;
    logic                stop_request_bit;
    logic                en;
    logic                gc_mode;
    logic                ack_plan;
    logic                sda_low;
    logic                scl_low;
    logic                busy;
    logic                start_pend;
    logic                arb_lost;
    logic [TCNT_W-1:0]   tcnt;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic                done;
    logic [31:0]         rdata;
  } i2csr_regs_t;

  i2csr_regs_t r_r;
  i2csr_regs_t r_nxt;

  logic [1:0] pin_sync;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       req;
  logic       wr_ok;
  logic [7:0] wbyte;

  // pins into the clock domain
  i2csr_sync u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .pin_in   ({scl_i, sda_i}),
    .pin_sync (pin_sync)
  );

  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];

  // start, stop and clock edge detection
  i2csr_cond u_cond (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // control bits packed for read-back
  function automatic logic [7:0] ctrl_word(input i2csr_regs_t s);
    ctrl_word          = 8'h00;
    ctrl_word[CTL_AA]  = s.aa;
    ctrl_word[CTL_SI]  = s.si;
    ctrl_word[CTL_STO] = s.stop_request_bit;
    ctrl_word[CTL_STA] = s.start_request_bit;
    ctrl_word[CTL_EN]  = s.en;
  endfunction

  // register read mux, unmapped offsets read zero
  function automatic logic [31:0] read_mux(input i2csr_regs_t s, input logic [4:0] a);
    read_mux = 32'h0000_0000;
    case (a)
      OFS_CTRL_SET: read_mux[7:0] = ctrl_word(s);
      OFS_STATUS:   read_mux[7:0] = s.si ? s.status : STS_NONE;
      OFS_DATA:     read_mux[7:0] = s.data;
      OFS_OWN_ADDR: read_mux[7:0] = s.own_addr;
      OFS_IRQ_STAT: read_mux[IRQ_W-1:0] = s.irq_stat;
      OFS_IRQ_MASK: read_mux[IRQ_W-1:0] = s.irq_mask;
      default:      read_mux = 32'h0000_0000;
    endcase
  endfunction

  // bus handshake: one wait cycle per access
  assign req   = avs_read | avs_write;
  assign wr_ok = avs_write & r_r.done & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always_comb begin
    r_nxt = r_r;

    // access acknowledge and read data capture
    r_nxt.done = req & ~r_r.done;
    if (avs_read && !r_r.done) begin
      r_nxt.rdata = read_mux(r_r, avs_address);
    end

    // software writes
    if (wr_ok) begin
      case (avs_address)
        OFS_CTRL_SET: begin
          if (wbyte[CTL_AA]) r_nxt.aa = 1'b1;
          if (wbyte[CTL_STO]) r_nxt.stop_request_bit = 1'b1;
          if (wbyte[CTL_STA]) r_nxt.start_request_bit = 1'b1;
          if (wbyte[CTL_EN]) r_nxt.en = 1'b1;
        end
        OFS_CTRL_CLR: begin
          if (wbyte[CTL_AA]) r_nxt.aa = 1'b0;
          if (wbyte[CTL_SI]) r_nxt.si = 1'b0;
          if (wbyte[CTL_STA]) r_nxt.start_request_bit = 1'b0;
          if (wbyte[CTL_EN]) r_nxt.en = 1'b0;
        end
        OFS_DATA:     r_nxt.data = wbyte;
        OFS_OWN_ADDR: r_nxt.own_addr = wbyte;
        OFS_IRQ_STAT: r_nxt.irq_stat = r_r.irq_stat & ~wbyte[IRQ_W-1:0];
        OFS_IRQ_MASK: r_nxt.irq_mask = wbyte[IRQ_W-1:0];
        default: ;
      endcase
    end

    // bus busy tracking and stop handling
    if (stop_det) begin
      r_nxt.busy               = 1'b0;
      r_nxt.irq_stat[IRQ_STOP] = 1'b1;
      if (r_r.st != ST_GEN && r_r.st != ST_MST && r_r.st != ST_STOP) begin
        r_nxt.st      = ST_IDLE;
        r_nxt.sda_low = 1'b0;
      end
    end

    // a foreign start while our own start waits means it was overtaken
    if (start_det) begin
      r_nxt.busy = 1'b1;
      if (r_r.start_pend && r_r.st != ST_GEN) begin
        r_nxt.arb_lost = 1'b1;
      end
      if (r_r.en && r_r.st != ST_GEN && r_r.st != ST_MST && r_r.st != ST_STOP) begin
        r_nxt.st      = ST_ADDR;
        r_nxt.bitcnt  = 4'h0;
        r_nxt.sda_low = 1'b0;
      end
    end

    if (!start_det && !stop_det) begin
      unique case (r_r.st)
        // wait for a pending start and a free bus
        ST_IDLE: begin
          if (r_r.start_pend && !r_r.busy && r_r.en) begin
            r_nxt.st      = ST_GEN;
            r_nxt.sda_low = 1'b1;
            r_nxt.tcnt    = '0;
          end
        end

        // shift in address or data bits on rising clock
        ST_ADDR, ST_DATA: begin
          if (scl_rise) begin
            r_nxt.shift  = {r_r.shift[6:0], sda_s};
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          end
          if (scl_fall && r_r.bitcnt == BITS_PER_BYTE) begin
            if (r_r.st == ST_ADDR) begin
              // own address write or general call, only with acknowledge set
              if (r_r.aa && r_r.shift[7:1] == r_r.own_addr[7:1] && !r_r.shift[0]) begin
                r_nxt.st          = ST_ACK;
                r_nxt.sda_low     = 1'b1;
                r_nxt.gc_mode     = 1'b0;
                r_nxt.arb_lost    = 1'b0;
                r_nxt.status_pend = r_r.arb_lost ? STS_ARB_OWN_W : STS_OWN_W;
              end else if (r_r.aa && r_r.shift == GC_ADDR && r_r.own_addr[0]) begin
                r_nxt.st          = ST_ACK;
                r_nxt.sda_low     = 1'b1;
                r_nxt.gc_mode     = 1'b1;
                r_nxt.arb_lost    = 1'b0;
                r_nxt.status_pend = r_r.arb_lost ? STS_ARB_GC : STS_GC;
              end else begin
                r_nxt.st = ST_SKIP;
              end
            end else begin
              // data byte answered as chosen when the flag was cleared
              r_nxt.st      = ST_ACK;
              r_nxt.sda_low = r_r.ack_plan;
              if (r_r.ack_plan) begin
                r_nxt.status_pend = r_r.gc_mode ? STS_GC_ACK : STS_OWN_ACK;
              end else begin
                r_nxt.status_pend = r_r.gc_mode ? STS_GC_NACK : STS_OWN_NACK;
              end
            end
          end
        end

        // end of acknowledge bit: raise flag and stretch the clock
        ST_ACK: begin
          if (scl_fall) begin
            r_nxt.sda_low          = 1'b0;
            r_nxt.scl_low          = 1'b1;
            r_nxt.si               = 1'b1;
            r_nxt.status           = r_r.status_pend;
            r_nxt.data             = r_r.shift;
            r_nxt.irq_stat[IRQ_SI] = 1'b1;
            r_nxt.st               = ST_HOLD;
          end
        end

        // clock held low until software clears the flag
        ST_HOLD: begin
          if (!r_r.si) begin
            r_nxt.scl_low = 1'b0;
            if (r_r.status == STS_OWN_NACK || r_r.status == STS_GC_NACK) begin
              r_nxt.st = ST_SKIP;
              if (r_r.start_request_bit) begin
                r_nxt.start_pend = 1'b1;
                r_nxt.start_request_bit        = 1'b0;
              end
            end else begin
              r_nxt.st       = ST_DATA;
              r_nxt.bitcnt   = 4'h0;
              r_nxt.ack_plan = r_r.aa;
            end
          end
        end

        // not addressed or data byte refused, wait for the next start or stop
        ST_SKIP: begin
          r_nxt.sda_low = 1'b0;
        end

        // hold data low with clock high, then pull the clock low
        ST_GEN: begin
          r_nxt.tcnt = r_r.tcnt + TCNT_W'(1);
          if (r_r.tcnt == TCNT_W'(START_HOLD_CYC - 1)) begin
            r_nxt.scl_low             = 1'b1;
            r_nxt.start_pend          = 1'b0;
            r_nxt.si                  = 1'b1;
            r_nxt.status              = STS_START_SENT;
            r_nxt.irq_stat[IRQ_SI]    = 1'b1;
            r_nxt.irq_stat[IRQ_START] = 1'b1;
            r_nxt.st                  = ST_MST;
          end
        end

        // bus owned; clearing the flag gives it back with a stop
        ST_MST: begin
          if (!r_r.si) begin
            r_nxt.scl_low = 1'b0;
            r_nxt.stop_request_bit     = 1'b0;
            r_nxt.tcnt    = '0;
            r_nxt.st      = ST_STOP;
          end
        end

        // release data after the clock has been high long enough
        ST_STOP: begin
          r_nxt.tcnt = r_r.tcnt + TCNT_W'(1);
          if (r_r.tcnt == TCNT_W'(STOP_BUF_CYC - 1)) begin
            r_nxt.sda_low = 1'b0;
            r_nxt.st      = ST_IDLE;
          end
        end
      endcase
    end

    // disabling the block drops the bus at once
    if (!r_r.en) begin
      r_nxt.st         = ST_IDLE;
      r_nxt.sda_low    = 1'b0;
      r_nxt.scl_low    = 1'b0;
      r_nxt.start_pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_r <= '{
        st:          ST_IDLE,
        bitcnt:      4'h0,
        shift:       8'h00,
        data:        8'h00,
        status:      STS_NONE,
        status_pend: STS_NONE,
        own_addr:    8'h00,
        aa:          1'b0,
        si:          1'b0,
        start_request_bit:         1'b0,
        stop_request_bit:         1'b0,
        en:          1'b0,
        gc_mode:     1'b0,
        ack_plan:    1'b0,
        sda_low:     1'b0,
        scl_low:     1'b0,
        busy:        1'b0,
        start_pend:  1'b0,
        arb_lost:    1'b0,
        tcnt:        '0,
        irq_stat:    '0,
        irq_mask:    '0,
        done:        1'b0,
        rdata:       32'h0000_0000
      };
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs
  assign avs_waitrequest = req & ~r_r.done;
  assign avs_readdata    = r_r.rdata;
  assign irq             = |(r_r.irq_stat & r_r.irq_mask);
  assign scl_o           = 1'b0;
  assign sda_o           = 1'b0;
  assign scl_oe_n        = ~r_r.scl_low; // low while pulling clock down
  assign sda_oe_n        = ~r_r.sda_low; // low while pulling data down

endmodule

/* testbench/i2csr_slave_rx_checker.sv */
`timescale 1ns/100ps
module i2csr_slave_rx_checker
  import i2csr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic clr_acc;

  // accepted write that clears the flag or the enable
  assign clr_acc = avs_write && !avs_waitrequest && avs_address == OFS_CTRL_CLR && avs_byteenable[0]
                   && (avs_writedata[CTL_SI] || avs_writedata[CTL_EN]);

  // register bus handshake, read data width, drive levels and reset release
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request waited more than one cycle");
  wait_idle_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait asserted without a request");
  wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new request not held for its wait cycle");
  rdata_high_a: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  drive_zero_a: assert property (!scl_o && !sda_o)
    else $error("open drain data not zero");
  reset_out_a: assert property (disable iff (1'b0) srst |=> scl_oe_n && sda_oe_n && !irq)
    else $error("outputs not released by reset");

  // line behaviour
  ack_hold_a: assert property ($fell(sda_oe_n) && !scl_i |-> !sda_oe_n [*6])
    else $error("acknowledge released too early");
  start_hold_a: assert property ($fell(sda_oe_n) && scl_i |-> (scl_oe_n && !sda_oe_n) [*8])
    else $error("start condition hold too short");
  stretch_hold_a: assert property ($rose(scl_oe_n) |-> $past(clr_acc) || $past(clr_acc, 2) || $past(clr_acc, 3))
    else $error("clock released without flag clear");
  stretch_free_a: assert property (clr_acc && !scl_oe_n |-> ##[1:3] scl_oe_n)
    else $error("clock still held after flag clear");

  // main scenarios reached
  ack_seen_c: cover property ($fell(sda_oe_n) && !scl_i);
  start_seen_c: cover property ($fell(sda_oe_n) && scl_i);
  stretch_seen_c: cover property (clr_acc && !scl_oe_n);
endmodule

bind i2csr_slave_rx i2csr_slave_rx_checker i2csr_slave_rx_checker_inst (
  .sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .irq, .scl_i, .scl_o, .scl_oe_n, .sda_i, .sda_o, .sda_oe_n
);

/* testbench/i2csr_bus_master.sv */
`timescale 1ns/100ps
module i2csr_bus_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  localparam int HALF = 24;

  // both lines released at start
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // release clock and wait while the slave stretches it
  task automatic rel_scl;
    int n;
    n = 0;
    scl_pull = 1'b0;
    while (scl !== 1'b1 && n < 20000) begin
      #1;
      n++;
    end
  endtask

  // start or repeated start, clock left low
  task automatic start;
    sda_pull = 1'b0;
    #HALF;
    rel_scl;
    #HALF;
    sda_pull = 1'b1;
    #HALF;
    scl_pull = 1'b1;
    #HALF;
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = !b[i];
      #HALF;
      rel_scl;
      #HALF;
      scl_pull = 1'b1;
    end
    sda_pull = 1'b0;
    #HALF;
    rel_scl;
    #(HALF / 2);
    ack = (sda === 1'b0);
    #(HALF / 2);
    scl_pull = 1'b1;
    #HALF;
  endtask

  // stop: data rises while clock high
  task automatic stop;
    sda_pull = 1'b1;
    #HALF;
    rel_scl;
    #HALF;
    sda_pull = 1'b0;
    #HALF;
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb
  import i2csr_pkg::*;
;
  typedef struct packed {
    logic       gc;
    logic       arb;
    logic       aa_a;
    logic [7:0] adr;
    logic       ack_a;
    logic [7:0] sts_a;
    logic       aa_d;
    logic [7:0] dat;
    logic       ack_d;
    logic [7:0] sts_d;
  } i2csr_row_t;
  localparam logic T = 1'b1;
  localparam logic F = 1'b0;

  logic        sys_clk;
  logic        srst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        scl_o;
  logic        scl_oe_n;
  logic        sda_o;
  logic        sda_oe_n;
  logic        scl_pull;
  logic        sda_pull;
  logic        scl_w;
  logic        sda_w;
  logic [31:0] q;
  logic        a;
  i2csr_row_t  r;
  int          fails;
  int          samples_checked;
  int          n;

  // ordinary receptions: address, answer, data byte, answer
  i2csr_row_t rows [9] = '{
    '{T, F, T, 8'h5A, T, STS_OWN_W,     T, 8'hA5, T, STS_OWN_ACK},
    '{T, T, T, 8'h5A, T, STS_ARB_OWN_W, T, 8'h5C, T, STS_OWN_ACK},
    '{T, F, T, 8'h00, T, STS_GC,        T, 8'h3C, T, STS_GC_ACK},
    '{T, T, T, 8'h00, T, STS_ARB_GC,    T, 8'hC3, T, STS_GC_ACK},
    '{T, F, T, 8'h5A, T, STS_OWN_W,     F, 8'h81, F, STS_OWN_NACK},
    '{T, F, F, 8'h5A, F, 8'h00,         F, 8'h00, F, 8'h00},
    '{F, F, T, 8'h00, F, 8'h00,         F, 8'h00, F, 8'h00},
    '{F, F, T, 8'h5A, T, STS_OWN_W,     F, 8'h7E, F, STS_OWN_NACK},
    '{T, F, T, 8'h5B, F, 8'h00,         F, 8'h00, F, 8'h00}
  };

  // open-drain lines with pull-up
  assign scl_w = !scl_pull && (scl_oe_n || scl_o);
  assign sda_w = !sda_pull && (sda_oe_n || sda_o);

  i2csr_slave_rx i2csr_slave_rx_inst (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
  );
  i2csr_bus_master i2csr_bus_master_inst (
    .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull)
  );

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // watchdog against a hung transfer
  initial begin
    #200000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize;
  end

  task automatic summarize;
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // one register access, held until wait drops
  task automatic bus(input logic w, input logic [4:0] adr, input logic [7:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= adr;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    // wait is sampled at the rising edge, read data taken at that same edge
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== F && k < 50);
    rd = avs_readdata;
    if (avs_waitrequest !== F) chk1(F, T, "bus answer");
    avs_write <= F;
    avs_read <= F;
  endtask

  // bounded wait for the flag interrupt, optionally clearing it
  task automatic wait_irq(input logic clr);
    int k;
    k = 0;
    while (irq !== T && k < 4000) begin
      @(negedge sys_clk);
      k++;
    end
    chk1(irq, T, "interrupt raised");
    if (clr) begin
      bus(T, OFS_IRQ_STAT, 8'h07, q);
      repeat (2) @(negedge sys_clk);
      chk1(irq, F, "interrupt cleared");
    end
  endtask

  // answer the flag with the chosen acknowledge, then take one byte
  task automatic rx_byte(input logic aa, input logic [7:0] d, input logic ack_e, input logic [7:0] sts_e);
    bus(T, aa ? OFS_CTRL_SET : OFS_CTRL_CLR, aa ? 8'h44 : 8'h04, q);
    bus(T, OFS_CTRL_CLR, 8'h08, q);
    i2csr_bus_master_inst.xbyte(d, a);
    chk1(a, ack_e, "data answer");
    wait_irq(T);
    bus(F, OFS_STATUS, 8'h00, q);
    chk8(q[7:0], sts_e, "data status");
    bus(F, OFS_DATA, 8'h00, q);
    chk8(q[7:0], d, "data byte");
  endtask

  // reset, register defaults, then the table and the awkward cases
  initial begin
    srst = T;
    avs_address = 5'h00;
    avs_read = F;
    avs_write = F;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(posedge sys_clk);
    srst <= F;
    bus(F, OFS_STATUS, 8'h00, q);
    chk8(q[7:0], STS_NONE, "idle status");
    bus(F, OFS_CTRL_SET, 8'h00, q);
    chk8(q[7:0], 8'h00, "control reset");
    bus(F, 5'h1C, 8'h00, q);
    chk8(q[7:0], 8'h00, "unmapped read");
    bus(T, OFS_OWN_ADDR, 8'h5B, q);
    avs_byteenable <= 4'h0;
    bus(T, OFS_OWN_ADDR, 8'h00, q);
    avs_byteenable <= 4'hF;
    bus(F, OFS_OWN_ADDR, 8'h00, q);
    chk8(q[7:0], 8'h5B, "lane off write");
    bus(T, OFS_IRQ_MASK, 8'h01, q);
    bus(T, OFS_CTRL_SET, 8'h40, q);
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      bus(T, OFS_OWN_ADDR, {7'h2D, r.gc}, q);
      bus(T, r.aa_a ? OFS_CTRL_SET : OFS_CTRL_CLR, r.aa_a ? 8'h44 : 8'h04, q);
      // pending start left by a refused byte, then overtaken by a repeated start
      if (r.arb) begin
        i2csr_bus_master_inst.start;
        i2csr_bus_master_inst.xbyte(8'h5A, a);
        wait_irq(T);
        rx_byte(F, 8'h11, F, STS_OWN_NACK);
        bus(T, OFS_CTRL_SET, 8'h64, q);
        bus(T, OFS_CTRL_CLR, 8'h08, q);
      end
      i2csr_bus_master_inst.start;
      i2csr_bus_master_inst.xbyte(r.adr, a);
      chk1(a, r.ack_a, "address answer");
      if (r.ack_a) begin
        wait_irq(T);
        bus(F, OFS_STATUS, 8'h00, q);
        chk8(q[7:0], r.sts_a, "address status");
        rx_byte(r.aa_d, r.dat, r.ack_d, r.sts_d);
        bus(T, OFS_CTRL_CLR, 8'h28, q);
      end
      i2csr_bus_master_inst.stop;
      // the still pending start goes out once the bus is free, then give it back
      if (r.arb) begin
        wait_irq(T);
        bus(F, OFS_STATUS, 8'h00, q);
        chk8(q[7:0], STS_START_SENT, "retried start status");
        bus(T, OFS_CTRL_CLR, 8'h08, q);
        repeat (STOP_BUF_CYC + 8) @(posedge sys_clk);
      end
    end
    // refused byte, start request left pending, start once the bus is free
    bus(T, OFS_OWN_ADDR, 8'h5A, q);
    bus(T, OFS_CTRL_SET, 8'h44, q);
    i2csr_bus_master_inst.start;
    i2csr_bus_master_inst.xbyte(8'h5A, a);
    wait_irq(T);
    rx_byte(F, 8'h99, F, STS_OWN_NACK);
    bus(T, OFS_CTRL_SET, 8'h20, q);
    bus(T, OFS_CTRL_CLR, 8'h08, q);
    i2csr_bus_master_inst.stop;
    n = 0;
    while (!(sda_w === F && scl_w === T) && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk1(sda_w, F, "start data low");
    chk1(scl_w, T, "start clock high");
    wait_irq(F);
    bus(F, OFS_STATUS, 8'h00, q);
    chk8(q[7:0], STS_START_SENT, "start status");
    bus(F, OFS_IRQ_STAT, 8'h00, q);
    chk8(q[7:0], 8'h07, "sticky events");
    // mask off, then only the start event, then clear all
    bus(T, OFS_IRQ_MASK, 8'h00, q);
    repeat (2) @(negedge sys_clk);
    chk1(irq, F, "masked interrupt");
    bus(T, OFS_IRQ_MASK, 8'h04, q);
    repeat (2) @(negedge sys_clk);
    chk1(irq, T, "start interrupt");
    bus(T, OFS_IRQ_STAT, 8'h07, q);
    repeat (2) @(negedge sys_clk);
    chk1(irq, F, "events cleared");
    // reset in mid-run while the clock is held
    @(posedge sys_clk);
    srst <= T;
    repeat (3) @(posedge sys_clk);
    srst <= F;
    @(negedge sys_clk);
    chk1(scl_oe_n, T, "clock released by reset");
    chk1(sda_oe_n, T, "data released by reset");
    bus(F, OFS_STATUS, 8'h00, q);
    chk8(q[7:0], STS_NONE, "status after reset");
    bus(F, OFS_CTRL_SET, 8'h00, q);
    chk8(q[7:0], 8'h00, "control after reset");
    summarize;
  end
endmodule
